// >>> sccm_consts.vh
`ifndef SCCM_CONSTS_VH
`define SCCM_CONSTS_VH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define SCCM_IDX_SELECT_A 14'h0280
`define SCCM_IDX_SELECT_B 14'h0281
`define SCCM_IDX_SELECT_C 14'h0282
`define SCCM_IDX_SLEW 14'h0283
`define SCCM_IDX_BW_LO 14'h0285
`define SCCM_IDX_BW_HI 14'h0286
`define SCCM_IDX_LOOP_SRC 14'h0287
`define SCCM_IDX_MODE 14'h0288
`define SCCM_IDX_STATUS 14'h3002

// ----------------------------------------
// field positions
// ----------------------------------------
`define SCCM_FLD_LO 0
`define SCCM_FLD_HI 4
`define SCCM_FLD_W 3
`define SCCM_RES_FLD_MSB 6
`define SCCM_STAT_HOLD 0
`define SCCM_STAT_LOCK 1
`define SCCM_STAT_FAULT 2

// ----------------------------------------
// reset values
// ----------------------------------------
`define SCCM_RST_SELECT 8'h00
`define SCCM_RST_SLEW 3'h0
`define SCCM_RST_LOOP_SRC 1'b0
`define SCCM_RST_MODE 1'b0
`define SCCM_RST_BW 16'h01F4

// ----------------------------------------
// arithmetic and timing
// ----------------------------------------
`define SCCM_FACTOR_W 48
`define SCCM_FRAC_BITS 40
`define SCCM_CLK_MHZ 100
`define SCCM_SLEW_TICK_US 1000
`define SCCM_SLEW_TICK_CYCLES (`SCCM_SLEW_TICK_US * `SCCM_CLK_MHZ)
// 0.715 ppm/s over one tick, in units of 2^-40
`define SCCM_SLEW_STEP_BASE 16'h0312

`endif

// >>> sccm_matrix.v
// Function
// R1: in closed loop, third factor recomputes on each stable-reference converter edge.
// R2: residual loop enters holdover on zero bandwidth or reference fault.
// R3: holdover freezes the third factor and holds the oscillator output static; in digitized clocking mode cc_update still loads the third factor.
// R4: cause gone and lock reported, loop closes and third factor updates again.
// R5: index 0..7 selects zero, single factors or their products.
// R6: each destination has its own writable selector field, 3 bits wide except the 2-bit residual loop field.
// R7: destinations are residual loop, reference converters, two aux oscillators, two main loops.
// R8: six selector fields packed into three 8-bit registers.
// R9: nonzero selection delivers a continuously updated combined correction stream.
// R10: combined correction rate of change is held within the selected limit.
// R11: limit code 0 means none; codes 1..7 give 0.715 doubling to 45.76 ppm/s.
// R12: one limit setting applies to combined outputs one through seven.
// R13: aux oscillator 0 selector sits in bits 2:0 of select register b.
// R14: software gives aux oscillator and reference converters identical selectors for timestamping.
// R15: software keeps factor two away from the main loop feeding method two.
// R16: factor three never reaches the residual loop; its field top bit is absent.
// R17: in digitized clocking mode the common clock loop supplies the third factor.
// R18: residual loop bandwidth is a 16-bit value over two registers, 0.1 Hz steps.
// R19: status bit 1 reads residual loop lock in real time.
// R20: reference monitor reads one for fault, zero when within limits.
// R21: a zero selector gives its destination no correction at all.
`include "sccm_consts.vh"
`default_nettype none

module sccm_matrix #(
    parameter W = `SCCM_FACTOR_W,
    parameter FRAC = `SCCM_FRAC_BITS,
    parameter SLEW_TICK_CYCLES = `SCCM_SLEW_TICK_CYCLES
) (
    // clock and reset
    input wire sys_clk,
    input wire resetn,
    // avalon-mm slave
    input wire [15:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // correction sources
    input wire signed [W-1:0] first_correction_factor,
    input wire signed [W-1:0] second_correction_factor,
    // residual loop
    input wire signed [W-1:0] res_cf3_in,
    input wire res_ref_edge,
    input wire res_lock,
    input wire res_ref_fault,
    output reg res_nco_static,
    output wire [15:0] residual_loop_bandwidth,
    // common clock loop
    input wire signed [W-1:0] cc_cf3_in,
    input wire cc_update,
    // method two source select
    output wire loop_source_sel,
    // destinations
    output wire signed [W-1:0] corr_residual,
    output wire signed [W-1:0] corr_ref_tdc,
    output wire signed [W-1:0] corr_aux0,
    output wire signed [W-1:0] corr_aux1,
    output wire signed [W-1:0] corr_main_loop_zero,
    output wire signed [W-1:0] corr_main_loop_one,
    output wire [5:0] corr_enable
);

// ----------------------------------------
// reset release
// ----------------------------------------
reg rst_meta_q;
reg rst_n;

always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        rst_meta_q <= 1'b0;
        rst_n <= 1'b0;
    end else begin
        rst_meta_q <= 1'b1;
        rst_n <= rst_meta_q;
    end
end

// ----------------------------------------
// register bus
// ----------------------------------------
reg ack_q;
reg [7:0] sel_a_q;
reg [7:0] sel_b_q;
reg [7:0] sel_c_q;
reg [2:0] slew_q;
reg [15:0] bw_q;
reg loop_src_q;
reg mode_q;
reg hold_q;

wire [13:0] idx = avs_address[15:2];
wire req = avs_read | avs_write;
wire wr_go = avs_write & ack_q & avs_byteenable[0];
wire [7:0] wd = avs_writedata[7:0];

assign avs_waitrequest = req & ~ack_q;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        ack_q <= 1'b0;
    end else begin
        ack_q <= req & ~ack_q;
    end
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        sel_a_q <= `SCCM_RST_SELECT;
        sel_b_q <= `SCCM_RST_SELECT;
        sel_c_q <= `SCCM_RST_SELECT;
        slew_q <= `SCCM_RST_SLEW;
        bw_q <= `SCCM_RST_BW;
        loop_src_q <= `SCCM_RST_LOOP_SRC;
        mode_q <= `SCCM_RST_MODE;
    end else if (wr_go) begin
        case (idx)
            `SCCM_IDX_SELECT_A: begin
                // residual loop field cannot hold factor three
                sel_a_q <= {1'b0, wd[5:4], 1'b0, wd[2:0]}; // see R16
            end
            `SCCM_IDX_SELECT_B: begin
                sel_b_q <= {1'b0, wd[6:4], 1'b0, wd[2:0]}; // see R13
            end
            `SCCM_IDX_SELECT_C: begin
                sel_c_q <= {1'b0, wd[6:4], 1'b0, wd[2:0]}; // see R8
            end
            `SCCM_IDX_SLEW: begin
                slew_q <= wd[2:0]; // see R11
            end
            `SCCM_IDX_BW_LO: begin
                bw_q[7:0] <= wd; // see R18
            end
            `SCCM_IDX_BW_HI: begin
                bw_q[15:8] <= wd; // see R18
            end
            `SCCM_IDX_LOOP_SRC: begin
                loop_src_q <= wd[0];
            end
            `SCCM_IDX_MODE: begin
                mode_q <= wd[0];
            end
            default: begin
            end
        endcase
    end
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_q) begin
        case (idx)
            `SCCM_IDX_SELECT_A: avs_readdata <= {24'h000000, sel_a_q};
            `SCCM_IDX_SELECT_B: avs_readdata <= {24'h000000, sel_b_q};
            `SCCM_IDX_SELECT_C: avs_readdata <= {24'h000000, sel_c_q};
            `SCCM_IDX_SLEW: avs_readdata <= {29'h00000000, slew_q};
            `SCCM_IDX_BW_LO: avs_readdata <= {24'h000000, bw_q[7:0]};
            `SCCM_IDX_BW_HI: avs_readdata <= {24'h000000, bw_q[15:8]};
            `SCCM_IDX_LOOP_SRC: avs_readdata <= {31'h00000000, loop_src_q};
            `SCCM_IDX_MODE: avs_readdata <= {31'h00000000, mode_q};
            `SCCM_IDX_STATUS: begin
                // live status, see R19, see R20
                avs_readdata <= {29'h00000000, res_ref_fault, res_lock, hold_q};
            end
            default: avs_readdata <= 32'h00000000;
        endcase
    end
end

assign residual_loop_bandwidth = bw_q;
assign loop_source_sel = loop_src_q;

// ----------------------------------------
// residual loop holdover
// ----------------------------------------
localparam ST_CLOSED = 1'b0;
localparam ST_HOLD = 1'b1;

reg state_q;
reg state_d;
reg signed [W-1:0] cf3_q;

wire hold_cause = (bw_q == 16'h0000) | res_ref_fault; // see R2

always @* begin
    state_d = state_q;
    case (state_q)
        ST_CLOSED: begin
            if (hold_cause) begin
                state_d = ST_HOLD; // see R2
            end
        end
        ST_HOLD: begin
            if (!hold_cause && res_lock) begin
                state_d = ST_CLOSED; // see R4
            end
        end
        default: begin
            state_d = ST_HOLD;
        end
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state_q <= ST_HOLD;
        hold_q <= 1'b1;
        res_nco_static <= 1'b1;
    end else begin
        state_q <= state_d;
        hold_q <= (state_d == ST_HOLD);
        res_nco_static <= (state_d == ST_HOLD); // see R3
    end
end

// third factor source and update
always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        cf3_q <= {W{1'b0}};
    end else if (mode_q) begin
        if (cc_update) begin
            cf3_q <= cc_cf3_in; // see R17
        end
    end else if (res_ref_edge && state_q == ST_CLOSED && !hold_cause) begin
        cf3_q <= res_cf3_in; // see R1, R3, R4
    end
end

// ----------------------------------------
// combiner
// ----------------------------------------
// (1+a)(1+b)-1 on fractional deviations
function signed [W-1:0] comb_f;
    input signed [W-1:0] a;
    input signed [W-1:0] b;
    reg signed [2*W-1:0] p;
    reg signed [W-1:0] s;
    begin
        p = a * b;
        s = a + b;
        comb_f = s + p[FRAC+W-1:FRAC];
    end
endfunction

reg signed [W-1:0] comb_q [1:7];
wire signed [W-1:0] cf12 = comb_f(first_correction_factor, second_correction_factor);

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        comb_q[1] <= {W{1'b0}};
        comb_q[2] <= {W{1'b0}};
        comb_q[3] <= {W{1'b0}};
        comb_q[4] <= {W{1'b0}};
        comb_q[5] <= {W{1'b0}};
        comb_q[6] <= {W{1'b0}};
        comb_q[7] <= {W{1'b0}};
    end else begin
        comb_q[1] <= first_correction_factor; // see R5
        comb_q[2] <= second_correction_factor;
        comb_q[3] <= cf12;
        comb_q[4] <= cf3_q;
        comb_q[5] <= comb_f(first_correction_factor, cf3_q);
        comb_q[6] <= comb_f(second_correction_factor, cf3_q);
        comb_q[7] <= comb_f(cf12, cf3_q);
    end
end

// ----------------------------------------
// slew rate limiting
// ----------------------------------------
localparam TW = 32;
localparam [TW-1:0] TICK_LAST = SLEW_TICK_CYCLES - 1;

reg [TW-1:0] tick_cnt_q;
reg tick_q;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        tick_cnt_q <= {TW{1'b0}};
        tick_q <= 1'b0;
    end else if (tick_cnt_q >= TICK_LAST) begin
        tick_cnt_q <= {TW{1'b0}};
        tick_q <= 1'b1;
    end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
        tick_q <= 1'b0;
    end
end

wire signed [W-1:0] lim [1:7];

genvar g;
generate
    for (g = 1; g < 8; g = g + 1) begin : g_slew
        // one shared limit code for all seven outputs, see R10, R12
        sccm_slew #(
            .W(W)
        ) u_slew (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .tick(tick_q),
            .rate_code(slew_q),
            .target(comb_q[g]),
            .value_q(lim[g])
        );
    end
endgenerate

// ----------------------------------------
// distributor
// ----------------------------------------
wire [2:0] dsel [0:5];

assign dsel[0] = {1'b0, sel_a_q[`SCCM_FLD_HI+1:`SCCM_FLD_HI]}; // see R16
assign dsel[1] = sel_a_q[`SCCM_FLD_LO+2:`SCCM_FLD_LO]; // see R7
assign dsel[2] = sel_b_q[`SCCM_FLD_LO+2:`SCCM_FLD_LO]; // see R13
assign dsel[3] = sel_b_q[`SCCM_FLD_HI+2:`SCCM_FLD_HI];
assign dsel[4] = sel_c_q[`SCCM_FLD_LO+2:`SCCM_FLD_LO];
assign dsel[5] = sel_c_q[`SCCM_FLD_HI+2:`SCCM_FLD_HI];

reg signed [W-1:0] corr_q [0:5];
reg [5:0] en_q;
integer d;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        for (d = 0; d < 6; d = d + 1) begin
            corr_q[d] <= {W{1'b0}};
        end
        en_q <= 6'h00;
    end else begin
        for (d = 0; d < 6; d = d + 1) begin
            if (dsel[d] == 3'h0) begin
                corr_q[d] <= {W{1'b0}}; // see R21
                en_q[d] <= 1'b0;
            end else begin
                corr_q[d] <= lim[dsel[d]]; // see R6, R9
                en_q[d] <= 1'b1;
            end
        end
    end
end

assign corr_residual = corr_q[0];
assign corr_ref_tdc = corr_q[1];
assign corr_aux0 = corr_q[2];
assign corr_aux1 = corr_q[3];
assign corr_main_loop_zero = corr_q[4];
assign corr_main_loop_one = corr_q[5];
assign corr_enable = en_q;

endmodule
`default_nettype wire

// >>> sccm_matrix_sva.sv
`include "sccm_consts.vh"
`default_nettype none
module sccm_matrix_sva #(parameter W = 48) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // register bus
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // residual loop and destinations
    input wire logic res_lock,
    input wire logic res_ref_fault,
    input wire logic res_nco_static,
    input wire logic [15:0] residual_loop_bandwidth,
    input wire logic signed [W-1:0] corr_residual,
    input wire logic [5:0] corr_enable
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles since reset release, covers the internal two-flop release
    logic [1:0] age_q;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) age_q <= 2'h0;
        else if (age_q != 2'h3) age_q <= age_q + 2'h1;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_wr_b;
        avs_write && !avs_waitrequest && avs_address[15:2] == `SCCM_IDX_SELECT_B && avs_byteenable[0];
    endsequence
    property p_one_wait;
        s_req |=> (avs_read || avs_write) && !avs_waitrequest;
    endproperty
    property p_first_wait;
        $rose(avs_read || avs_write) |-> avs_waitrequest;
    endproperty
    property p_idle;
        !(avs_read || avs_write) |-> !avs_waitrequest;
    endproperty
    property p_rdata;
        avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0;
    endproperty
    property p_zero_res;
        !corr_enable[0] |-> corr_residual == '0;
    endproperty
    property p_bw_hold;
        residual_loop_bandwidth == 16'h0 |=> res_nco_static;
    endproperty
    property p_fault_hold;
        res_ref_fault |=> res_nco_static;
    endproperty
    property p_close;
        age_q == 2'h3 && res_nco_static && res_lock && !res_ref_fault
            && residual_loop_bandwidth != 16'h0 |=> !res_nco_static;
    endproperty
    property p_open;
        $fell(res_nco_static) |-> $past(res_lock) && !$past(res_ref_fault);
    endproperty
    property p_sel_on;
        s_wr_b ##0 avs_writedata[6:4] != 3'h0 |=> ##1 corr_enable[3];
    endproperty
    property p_sel_off;
        s_wr_b ##0 avs_writedata[2:0] == 3'h0 |=> ##1 !corr_enable[2];
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait not one cycle");
    a_first_wait: assert property (p_first_wait) else $error("no first wait");
    a_idle: assert property (p_idle) else $error("wait while idle");
    a_rdata: assert property (p_rdata) else $error("upper read bits set");
    a_zero_res: assert property (p_zero_res) else $error("unselected output");
    a_bw_hold: assert property (p_bw_hold) else $error("no hold on bw");
    a_fault_hold: assert property (p_fault_hold) else $error("no hold on fault");
    a_close: assert property (p_close) else $error("loop not closed");
    a_open: assert property (p_open) else $error("closed without lock");
    a_sel_on: assert property (p_sel_on) else $error("aux1 not enabled");
    a_sel_off: assert property (p_sel_off) else $error("aux0 not off");
endmodule
bind sccm_matrix sccm_matrix_sva #(.W(W)) u_sva (
    .sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .res_lock, .res_ref_fault, .res_nco_static,
    .residual_loop_bandwidth, .corr_residual, .corr_enable
);
`default_nettype wire

// >>> sccm_slew.v
`include "sccm_consts.vh"
`default_nettype none

module sccm_slew #(
    parameter W = `SCCM_FACTOR_W
) (
    // clock and reset
    input wire sys_clk,
    input wire rst_n,
    // control
    input wire tick,
    input wire [2:0] rate_code,
    // data
    input wire signed [W-1:0] target,
    output reg signed [W-1:0] value_q
);

// ----------------------------------------
// step per tick doubles with each code
// ----------------------------------------
wire [W:0] step_base = {{(W-15){1'b0}}, `SCCM_SLEW_STEP_BASE};
wire [2:0] shift = rate_code - 3'h1;
wire signed [W:0] step = $signed(step_base << shift);
wire signed [W:0] diff = {target[W-1], target} - {value_q[W-1], value_q};
wire signed [W:0] value_ext = {value_q[W-1], value_q};
wire signed [W:0] up = value_ext + step;
wire signed [W:0] down = value_ext - step;

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        value_q <= {W{1'b0}};
    end else if (rate_code == 3'h0) begin
        value_q <= target;
    end else if (tick) begin
        if (diff > step) begin
            value_q <= up[W-1:0];
        end else if (diff < -step) begin
            value_q <= down[W-1:0];
        end else begin
            value_q <= target;
        end
    end
end

endmodule
`default_nettype wire

// >>> tb_top.sv
`include "sccm_consts.vh"
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 48;
    localparam logic signed [W-1:0] FA = 48'sh0010_0000_0000;
    localparam logic signed [W-1:0] FB = 48'sh0020_0000_0000;
    localparam logic signed [W-1:0] FC = 48'sh0008_0000_0000;
    localparam logic signed [W-1:0] FD = 48'sh0004_0000_0000;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] avs_address = 16'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic signed [W-1:0] first_correction_factor = FA;
    logic signed [W-1:0] second_correction_factor = FB;
    logic signed [W-1:0] res_cf3_in = '0;
    logic signed [W-1:0] cc_cf3_in = '0;
    logic res_ref_edge = 1'b0;
    logic res_lock = 1'b0;
    logic res_ref_fault = 1'b0;
    logic cc_update = 1'b0;
    logic res_nco_static;
    logic loop_source_sel;
    logic [15:0] residual_loop_bandwidth;
    logic signed [W-1:0] corr_residual, corr_ref_tdc, corr_aux0, corr_aux1;
    logic signed [W-1:0] corr_main_loop_zero, corr_main_loop_one;
    logic [5:0] corr_enable;
    int bad_count = 0;
    int n_compared = 0;

    sccm_matrix #(.SLEW_TICK_CYCLES(10)) dut (
        .sys_clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .first_correction_factor,
        .second_correction_factor, .res_cf3_in, .res_ref_edge, .res_lock, .res_ref_fault,
        .res_nco_static, .residual_loop_bandwidth, .cc_cf3_in, .cc_update, .loop_source_sel,
        .corr_residual, .corr_ref_tdc, .corr_aux0, .corr_aux1, .corr_main_loop_zero,
        .corr_main_loop_one, .corr_enable
    );

    always #5 sys_clk = ~sys_clk;

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        bit done;
        done = 0;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_read <= !wr;
        avs_write <= wr;
        for (int i = 0; i < 20 && !done; i++) begin
            @(posedge sys_clk);
            done = (avs_waitrequest === 1'b0);
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (!done) begin bad_count++; print_verdict(); end
    endtask

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rdc(input logic [13:0] idx, input logic [7:0] ex);
        logic [7:0] x;
        bus(1'b0, idx, 8'h00, x);
        `CHK("register", ex, x)
    endtask

    task automatic pulse(input logic signed [W-1:0] v);
        @(posedge sys_clk);
        res_cf3_in <= v;
        res_ref_edge <= 1'b1;
        @(posedge sys_clk);
        res_ref_edge <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask

    function automatic logic signed [W-1:0] cmb(input logic signed [W-1:0] a,
                                                input logic signed [W-1:0] b);
        logic signed [2*W-1:0] p;
        p = a * b;
        return a + b + p[W-1+`SCCM_FRAC_BITS:`SCCM_FRAC_BITS];
    endfunction

    task automatic t_regs();
        rdc(`SCCM_IDX_SELECT_A, 8'h00);
        rdc(`SCCM_IDX_SLEW, 8'h00);
        rdc(`SCCM_IDX_BW_LO, 8'hF4);
        rdc(`SCCM_IDX_BW_HI, 8'h01);
        wr(`SCCM_IDX_SELECT_A, 8'hFF);
        rdc(`SCCM_IDX_SELECT_A, 8'h37);
        wr(`SCCM_IDX_SELECT_B, 8'hFF);
        rdc(`SCCM_IDX_SELECT_B, 8'h77);
        wr(14'h0284, 8'hFF);
        rdc(14'h0284, 8'h00);
        wr(`SCCM_IDX_LOOP_SRC, 8'h01);
        @(posedge sys_clk);
        `CHK("loop source", 1'b1, loop_source_sel)
        avs_byteenable <= 4'h0;
        wr(`SCCM_IDX_SLEW, 8'h07);
        avs_byteenable <= 4'hF;
        rdc(`SCCM_IDX_SLEW, 8'h00);
    endtask

    task automatic t_comb();
        logic signed [W-1:0] ex [8];
        ex = '{'0, FA, FB, cmb(FA, FB), FC, cmb(FA, FC), cmb(FB, FC), cmb(cmb(FA, FB), FC)};
        res_lock <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK("hold flag", 1'b0, res_nco_static)
        pulse(FC);
        for (int k = 0; k < 8; k++) begin
            wr(`SCCM_IDX_SELECT_A, {2'b00, k[1:0], 1'b0, k[2:0]});
            wr(`SCCM_IDX_SELECT_B, {1'b0, k[2:0], 1'b0, k[2:0]});
            // loop source is one: factor two kept off main loop one
            wr(`SCCM_IDX_SELECT_C, {1'b0, k[2], 1'b0, k[0], 1'b0, k[2:0]});
            repeat (6) @(posedge sys_clk);
            `CHK("residual", ex[k[1:0]], corr_residual)
            `CHK("ref tdc", ex[k], corr_ref_tdc)
            `CHK("aux0", ex[k], corr_aux0)
            `CHK("aux1", ex[k], corr_aux1)
            `CHK("main0", ex[k], corr_main_loop_zero)
            `CHK("main1", ex[{k[2], 1'b0, k[0]}], corr_main_loop_one)
            `CHK("enables", {(k[2] | k[0]), {4{k != 0}}, k[1:0] != 2'b00}, corr_enable)
        end
    endtask

    task automatic t_hold();
        wr(`SCCM_IDX_SELECT_B, 8'h04);
        wr(`SCCM_IDX_BW_LO, 8'h00);
        wr(`SCCM_IDX_BW_HI, 8'h00);
        repeat (2) @(posedge sys_clk);
        `CHK("hold flag", 1'b1, res_nco_static)
        rdc(`SCCM_IDX_STATUS, 8'h03);
        pulse(FD);
        `CHK("frozen", FC, corr_aux0)
        wr(`SCCM_IDX_BW_LO, 8'hF4);
        wr(`SCCM_IDX_BW_HI, 8'h01);
        `CHK("hold flag", 1'b0, res_nco_static)
        pulse(FD);
        `CHK("resumed", FD, corr_aux0)
        `CHK("bandwidth", 16'h01F4, residual_loop_bandwidth)
        res_ref_fault <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rdc(`SCCM_IDX_STATUS, 8'h07);
        pulse(FC);
        `CHK("frozen", FD, corr_aux0)
        res_ref_fault <= 1'b0;
        wr(`SCCM_IDX_MODE, 8'h01);
        cc_cf3_in <= FC;
        cc_update <= 1'b1;
        @(posedge sys_clk);
        cc_update <= 1'b0;
        repeat (8) @(posedge sys_clk);
        `CHK("common clock", FC, corr_aux0)
        wr(`SCCM_IDX_MODE, 8'h00);
    endtask

    task automatic t_slew();
        logic signed [W-1:0] prev;
        wr(`SCCM_IDX_SELECT_B, 8'h11);
        wr(`SCCM_IDX_SLEW, 8'h01);
        first_correction_factor <= FA + 48'sd5000;
        for (int i = 0; i < 6; i++) begin
            prev = corr_aux0;
            repeat (10) @(posedge sys_clk);
            `CHK("step", 1'b1, (corr_aux0 - prev) <= 48'sd786)
            `CHK("aux1 step", corr_aux0, corr_aux1)
        end
        repeat (200) @(posedge sys_clk);
        `CHK("landed", FA + 48'sd5000, corr_aux0)
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_comb();
        t_hold();
        t_slew();
        print_verdict();
    end
endmodule
`default_nettype wire
